// ==== design/birm_core.v ====
/*
 * interrupt routing and mailbox core: steering word, enable word,
 * pending status, soft irq triggers and three mailbox words.
 * assumes a single-cycle register port with read data one cycle later,
 * and source events given as one-cycle pulses synchronous to clk.
 */
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
`include "birm_consts.vh"

// Notes on behaviour
// [R1] pci error log steered by its bit
// [R2] local error log steered by its bit
// [R3] master parity detect steered by its bit
// [R4] pci status set steered by its bit
// [R5] four dma interrupts each steered
// [R6] five sources fixed to local bus
// [R7] local irq input fixed to pci
// [R8] outbound post nonempty fixed to pci
// [R9] four mailbox interrupts each steered, reset 0
// [R10] local parity error steered by its bit
// [R11] four list interrupts each steered
// [R12] soft irqs 0 to 3 steered, reset 0
// [R13] source needs enable bit to reach bus; soft irqs 0 to 3 reach it ungated
// [R14] write 1 sets soft irq3 pending, reads 0
// [R15] write 1 sets soft irq2 pending, reads 0
// [R16] trigger word for soft irq 2/3 at 60c
// [R17] mailbox 0 at 700, cleared by reset
// [R18] mailboxes 1 and 2 at 704, 708
// [R19] enable bits reset to 0 blocking sources
// [R20] soft irq 0/1 triggered from enable word
// [R21] bus output high while any routed pending
// [R22] mailbox write raises its pending bit
module birm_core
(
    input wire clk,
    input wire rst,
    input wire [11:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata_ff,
    input wire [31:0] src_event,
    output reg local_irq_ff,
    output reg pci_irq_ff
);

    // ==========================================================
    // state
    reg [31:0] steer_ff;
    reg [31:0] enable_ff;
    reg [31:0] pend_ff;
    reg [31:0] mailbox_word_0_ff;
    reg [31:0] mailbox_word_1_ff;
    reg [31:0] mailbox_word_2_ff;
    reg [31:0] nxt_pend;
    reg [31:0] nxt_rdata;
    reg [31:0] set_vec;
    wire [31:0] steer_eff;
    wire [31:0] live;

    function hit;
        input [11:0] a;
        input [11:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    // ==========================================================
    // routing
    // fixed bits forced here so a stray write can never move them
    assign steer_eff = (steer_ff & `BIRM_STEER_RW_MASK) | `BIRM_STEER_FIXED_ONE; // [R6] [R7] [R8]
    assign live = pend_ff & enable_ff; // [R13]

    // ==========================================================
    // pending set/clear; set beats a same-cycle write-one-to-clear
    always @*
    begin
        set_vec = src_event & `BIRM_SRC_MASK;
        if (reg_wr && hit(reg_addr, `BIRM_OFS_ENABLE))
        begin
            set_vec[`BIRM_B_SOFT_IRQ0] = reg_wdata[`BIRM_B_SOFT_IRQ0]; // [R20]
            set_vec[`BIRM_B_SOFT_IRQ1] = reg_wdata[`BIRM_B_SOFT_IRQ1]; // [R20]
        end
        if (reg_wr && hit(reg_addr, `BIRM_OFS_TRIG_HI)) // [R16]
        begin
            set_vec[`BIRM_B_SOFT_IRQ2] = reg_wdata[`BIRM_B_SOFT_IRQ2]; // [R15]
            set_vec[`BIRM_B_SOFT_IRQ3] = reg_wdata[`BIRM_B_SOFT_IRQ3]; // [R14]
        end
        set_vec[`BIRM_B_MAILBOX0] = reg_wr && hit(reg_addr, `BIRM_OFS_MAILBOX_WORD_0); // [R22]
        set_vec[`BIRM_B_MAILBOX1] = reg_wr && hit(reg_addr, `BIRM_OFS_MAILBOX_WORD_1); // [R22]
        set_vec[`BIRM_B_MAILBOX2] = reg_wr && hit(reg_addr, `BIRM_OFS_MAILBOX_WORD_2); // [R22]
        // mailbox 3 lives elsewhere; its event comes in on the source vector
        set_vec[`BIRM_B_MAILBOX3] = src_event[`BIRM_B_MAILBOX3];
        nxt_pend = pend_ff;
        if (reg_wr && hit(reg_addr, `BIRM_OFS_STATUS))
        begin
            nxt_pend = pend_ff & ~reg_wdata;
        end
        nxt_pend = nxt_pend | set_vec;
    end

    // ==========================================================
    // read mux; trigger bits always read back zero
    always @*
    begin
        nxt_rdata = `BIRM_ZERO32;
        if (reg_rd)
        begin
            case (reg_addr)
                `BIRM_OFS_STEER: nxt_rdata = steer_eff;
                `BIRM_OFS_ENABLE: nxt_rdata = enable_ff & `BIRM_ENABLE_RW_MASK; // [R20]
                `BIRM_OFS_STATUS: nxt_rdata = pend_ff;
                `BIRM_OFS_TRIG_HI: nxt_rdata = `BIRM_ZERO32; // [R14] [R15]
                `BIRM_OFS_MAILBOX_WORD_0: nxt_rdata = mailbox_word_0_ff; // [R17]
                `BIRM_OFS_MAILBOX_WORD_1: nxt_rdata = mailbox_word_1_ff; // [R18]
                `BIRM_OFS_MAILBOX_WORD_2: nxt_rdata = mailbox_word_2_ff; // [R18]
                default: nxt_rdata = `BIRM_ZERO32;
            endcase
        end
    end

    // ==========================================================
    // registers
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            steer_ff <= `BIRM_STEER_FIXED_ONE; // [R9] [R12]
            enable_ff <= `BIRM_ZERO32; // [R19]
            pend_ff <= `BIRM_ZERO32;
            mailbox_word_0_ff <= `BIRM_ZERO32; // [R17]
            mailbox_word_1_ff <= `BIRM_ZERO32; // [R18]
            mailbox_word_2_ff <= `BIRM_ZERO32; // [R18]
            reg_rdata_ff <= `BIRM_ZERO32;
            local_irq_ff <= 1'b0;
            pci_irq_ff <= 1'b0;
        end
        else
        begin
            if (reg_wr && hit(reg_addr, `BIRM_OFS_STEER))
            begin
                // covers R1-R5, R9-R12: writable steering bits
                steer_ff <= (reg_wdata & `BIRM_STEER_RW_MASK) | `BIRM_STEER_FIXED_ONE; // [R1] [R2] [R3] [R4] [R5] [R9] [R10] [R11] [R12]
            end
            if (reg_wr && hit(reg_addr, `BIRM_OFS_ENABLE))
            begin
                enable_ff <= reg_wdata & `BIRM_ENABLE_RW_MASK;
            end
            if (reg_wr && hit(reg_addr, `BIRM_OFS_MAILBOX_WORD_0))
            begin
                mailbox_word_0_ff <= reg_wdata; // [R17]
            end
            if (reg_wr && hit(reg_addr, `BIRM_OFS_MAILBOX_WORD_1))
            begin
                mailbox_word_1_ff <= reg_wdata; // [R18]
            end
            if (reg_wr && hit(reg_addr, `BIRM_OFS_MAILBOX_WORD_2))
            begin
                mailbox_word_2_ff <= reg_wdata; // [R18]
            end
            pend_ff <= nxt_pend;
            reg_rdata_ff <= nxt_rdata;
            // soft irq enables share the trigger nibble, so soft irqs pass ungated
            local_irq_ff <= |((live | (pend_ff & `BIRM_SOFT_MASK)) & ~steer_eff); // [R21]
            pci_irq_ff <= |((live | (pend_ff & `BIRM_SOFT_MASK)) & steer_eff); // [R21]
        end
    end

endmodule // birm_core

// ==== design/birm_consts.vh ====
/*
 * constants for the bridge interrupt routing and mailbox block:
 * register offsets, bit positions of the direction and control words,
 * fixed direction values and reset values.
 * assumes a byte-addressed register port of 12 address bits.
 */
`ifndef BIRM_CONSTS_VH
`define BIRM_CONSTS_VH

// ==========================================================
// register offsets
`define BIRM_OFS_STEER 12'h608
`define BIRM_OFS_ENABLE 12'h600
`define BIRM_OFS_STATUS 12'h604
`define BIRM_OFS_TRIG_HI 12'h60c
`define BIRM_OFS_MAILBOX_WORD_0 12'h700
`define BIRM_OFS_MAILBOX_WORD_1 12'h704
`define BIRM_OFS_MAILBOX_WORD_2 12'h708

// ==========================================================
// source bit positions, shared by enable, status and steering words
`define BIRM_B_PCI_ERRLOG 31
`define BIRM_B_LOCAL_ERRLOG 30
`define BIRM_B_MASTER_PARITY 29
`define BIRM_B_PCI_STATUS_SET 28
`define BIRM_B_DMA_LOCAL_ERR 27
`define BIRM_B_DMA_PCI_ERR 26
`define BIRM_B_DMA_RESET 25
`define BIRM_B_DMA_DONE 24
`define BIRM_B_PCI_IRQ_IN 23
`define BIRM_B_PCI_PARITY 22
`define BIRM_B_SYSTEM_ERROR 21
`define BIRM_B_LOCAL_IRQ_IN 20
`define BIRM_B_MAILBOX3 19
`define BIRM_B_MAILBOX2 18
`define BIRM_B_MAILBOX1 17
`define BIRM_B_MAILBOX0 16
`define BIRM_B_LOCAL_PARITY 15
`define BIRM_B_POWER_CHANGE 14
`define BIRM_B_OUT_POST_NONEMPTY 13
`define BIRM_B_IN_POST_NEW 12
`define BIRM_B_SOFT_IRQ3 3
`define BIRM_B_SOFT_IRQ2 2
`define BIRM_B_SOFT_IRQ1 1
`define BIRM_B_SOFT_IRQ0 0

// ==========================================================
// writable steering bits and the fixed ones (which read 1 / 0)
`define BIRM_STEER_RW_MASK 32'hff0f_8f0f
`define BIRM_STEER_FIXED_ONE 32'h0010_2000
// soft irq triggers live in the low nibble of the enable and trigger words
`define BIRM_ENABLE_RW_MASK 32'hffff_fffc
// mailbox 0-2 and soft irq bits are set by writes only, bits 7:4 unused
`define BIRM_SRC_MASK 32'hfff8_ff00
`define BIRM_SOFT_MASK 32'h0000_000f
`define BIRM_ZERO32 32'h0000_0000

`endif

// ==== test/birm_core_monitor.sv ====
/* port checker of the routing core; assumes one clock, async active high rst */
`timescale 1ns/100ps
module birm_core_monitor (
    input logic clk, rst, reg_wr, reg_rd, local_irq_ff, pci_irq_ff,
    input logic [11:0] reg_addr,
    input logic [31:0] reg_wdata, reg_rdata_ff, src_event
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire cause = reg_wr || src_event != 32'h0;
    trig_zero_a: assert property (reg_rd && reg_addr == 12'h60c |=>
        reg_rdata_ff == 32'h0) else $error("trigger read");
    fixed_dir_a: assert property (reg_rd && reg_addr == 12'h608 |=>
        (reg_rdata_ff & 32'h00f07000) == 32'h00102000) else $error("fixed steer");
    trig_low_a: assert property (reg_rd && reg_addr == 12'h600 |=>
        reg_rdata_ff[1:0] == 2'h0) else $error("enable low bits");
    mbox_back_a: assert property (reg_wr && reg_addr == 12'h700 ##1
        reg_rd && reg_addr == 12'h700 |=> reg_rdata_ff == $past(reg_wdata, 2)) else $error("mbox");
    loc_rise_a: assert property ($rose(local_irq_ff) |-> $past(cause, 2))
        else $error("local rise");
    pci_rise_a: assert property ($rose(pci_irq_ff) |-> $past(cause, 2))
        else $error("pci rise");
    loc_fall_a: assert property ($fell(local_irq_ff) |-> $past(reg_wr, 2))
        else $error("local fall");
    pci_fall_a: assert property ($fell(pci_irq_ff) |-> $past(reg_wr, 2))
        else $error("pci fall");
    cover property (local_irq_ff && pci_irq_ff);
    cover property (reg_wr && reg_addr == 12'h60c);
    cover property ($fell(pci_irq_ff));
endmodule // birm_core_monitor
bind birm_core birm_core_monitor mon (.*);

// ==== test/birm_src.sv ====
/* far side event model: source pulses on request; assumes requests last one clock */
`timescale 1ns/100ps
module birm_src (
    input logic [31:0] pick,
    output logic [31:0] src_event
);
    // pulses exist only while asked for, so no stale event is seen twice
    assign src_event = pick;
endmodule // birm_src

// ==== test/birm_tb_top.sv ====
/* bench for the routing core; assumes birm_core and the birm_src event model */
`timescale 1ns/100ps
module bridge_interrupt_routing_mailboxes_tb_top;
    logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, local_irq_ff, pci_irq_ff;
    logic [11:0] reg_addr = 12'h0;
    logic [31:0] reg_wdata = 32'h0, pick = 32'h0, reg_rdata_ff, src_event;
    int n_mismatch = 0, n_tests = 0;
    always #20 clk = ~clk;
    birm_src src (.*);
    birm_core dut (.*);
    task chk(input logic [33:0] e, input logic [33:0] g);
        n_tests++;
        n_mismatch += (g !== e);
        if (g !== e) $display("MISMATCH rdata_irq exp %h got %h", e, g);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        reg_wr <= 1'b1;
        {reg_addr, reg_wdata} <= {a, d};
        @(posedge clk);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] ie);
        {reg_wr, reg_rd, reg_addr} <= {2'b01, a};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk({e, ie}, {reg_rdata_ff, local_irq_ff, pci_irq_ff});
        @(posedge clk);
    endtask
    task wrap_up;
        if (n_mismatch == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task t_regs;
        rd(12'h608, 32'h00102000, 2'b00);
        wr(12'h700, 32'ha5a50001);
        rd(12'h700, 32'ha5a50001, 2'b00);
        wr(12'h708, 32'h5a5a0002);
        rd(12'h604, 32'h00050000, 2'b00);
    endtask
    task t_irq;
        wr(12'h608, 32'hffffffff);
        pick <= 32'h80104000;
        wr(12'h600, 32'h80104003);
        pick <= 32'h0;
        rd(12'h608, 32'hff1faf0f, 2'b11);
        wr(12'h60c, 32'h00000008);
        rd(12'h60c, 32'h0, 2'b11);
        wr(12'h600, 32'h0);
        wr(12'h608, 32'h0);
        wr(12'h60c, 32'h00000004);
        rd(12'h604, 32'h8015400f, 2'b10);
        rd(12'h600, 32'h0, 2'b10);
    endtask
    task t_more;
        wr(12'h704, 32'h0000c3c3);
        rd(12'h704, 32'h0000c3c3, 2'b10);
        wr(12'h604, 32'hffffffff);
        rd(12'h604, 32'h0, 2'b00);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rd(12'h608, 32'h00102000, 2'b00);
        rd(12'h600, 32'h0, 2'b00);
        rd(12'h704, 32'h0, 2'b00);
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_irq;
        t_more;
        wrap_up;
    end
    initial
    begin
        #8000 n_mismatch++;
        wrap_up;
    end
endmodule // bridge_interrupt_routing_mailboxes_tb_top
